/* core/pmc_pkg.sv */
// paging mode control package: register map, bit positions, types
package pmc_pkg;

    // register byte offsets on the control bus
    localparam logic [3:0] PMC_OFF_CW0  = 4'h0;
    localparam logic [3:0] PMC_OFF_CW4  = 4'h4;
    localparam logic [3:0] PMC_OFF_EFR  = 4'h8;
    localparam logic [3:0] PMC_OFF_STAT = 4'hc;

    // control_word_zero bit positions
    localparam int PMC_B_PE  = 0;
    localparam int PMC_B_WP  = 16;
    localparam int PMC_B_PG  = 31;
    // control_word_four bit positions
    localparam int PMC_B_PSE = 4;
    localparam int PMC_B_PAE = 5;
    localparam int PMC_B_PGE = 7;
    localparam int PMC_B_CID = 17;
    localparam int PMC_B_SMP = 20;
    // extended_feature_reg bit positions
    localparam int PMC_B_LME = 8;
    localparam int PMC_B_LMA = 10;
    localparam int PMC_B_NXE = 11;

    // storable bits of each register, all else reads zero except the derived long-active bit
    localparam logic [31:0] PMC_MASK_CW0 = 32'h8001_0001;
    localparam logic [31:0] PMC_MASK_CW4 = 32'h0012_00b0;
    localparam logic [31:0] PMC_MASK_EFR = 32'h0000_0900;
    localparam logic [31:0] PMC_RST_REG  = 32'h0000_0000;

    // address widths
    localparam int PMC_LIN_W  = 48;
    localparam int PMC_PHY_W  = 52;
    localparam int PMC_LEG_W  = 32;
    localparam int PMC_PSE_W  = 40;
    localparam int PMC_CANON  = 47;

    localparam logic [1:0]  PMC_CPL_USER = 2'h3;
    localparam logic [15:0] PMC_GP_CODE  = 16'h0000;
    localparam logic [1:0]  PMC_RESP_OK  = 2'h0;
    localparam logic [1:0]  PMC_RESP_SLV = 2'h2;
    localparam logic [1:0]  PMC_RESP_DEC = 2'h3;

    typedef enum logic [1:0] {
        PMC_MODE_OFF,
        PMC_MODE_TWO,
        PMC_MODE_EXT,
        PMC_MODE_FOUR
    } pmc_mode_t;

    // effective translation modifiers
    typedef struct packed {
        logic wp;
        logic large_page_enable;
        logic global_page_enable;
        logic cid;
        logic sup_exec_prevent;
        logic exec_disable_enable;
    } pmc_mods_t;

    // translation check request from pipeline and walker
    typedef struct packed {
        logic        valid;
        logic [63:0] lin;
        logic        sub64;
        logic [1:0]  current_privilege;
        logic        write;
        logic        fetch;
        logic        pg_ro;
        logic        pg_user;
        logic        pg_xd;
        logic        pg_large;
        logic [51:0] walk_phys;
    } pmc_xl_req_t;

    typedef struct packed {
        logic        valid;
        logic        gp;
        logic        deny;
        logic [47:0] lin;
        logic [51:0] phys;
    } pmc_xl_rsp_t;

endpackage : pmc_pkg

/* core/pmc_xlate_chk.sv */
// translation checker: address widths, canonical test, access denial
`timescale 1ns/100ps
`default_nettype none
module pmc_xlate_chk import pmc_pkg::*; (
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    input  wire pmc_mode_t   i_mode,
    input  wire pmc_mods_t   i_mods,
    input  wire pmc_xl_req_t i_req,
    output var  pmc_xl_rsp_t o_rsp
);
    logic        canon_ok;
    logic [51:0] phys_mask;
    logic        deny;

    // bits 63:47 must all match in 64-bit sub-mode
    assign canon_ok = (&i_req.lin[63:PMC_CANON]) | ~(|i_req.lin[63:PMC_CANON]);

    // output width: 40 bits only for large two-level pages
    always_comb begin
        phys_mask = '1;
        if (i_mode == PMC_MODE_TWO) begin
            if (i_req.pg_large && i_mods.large_page_enable) begin
                phys_mask = 52'((64'h1 << PMC_PSE_W) - 64'h1);
            end else begin
                phys_mask = 52'((64'h1 << PMC_LEG_W) - 64'h1);
            end
        end
    end

    // read-only, supervisor fetch and execute-disable checks
    always_comb begin
        deny = 1'b0;
        if (i_req.write && i_req.pg_ro && (i_req.current_privilege == PMC_CPL_USER || i_mods.wp)) begin
            deny = 1'b1;
        end
        if (i_req.fetch && i_req.pg_user && i_req.current_privilege != PMC_CPL_USER && i_mods.sup_exec_prevent) begin
            deny = 1'b1;
        end
        if (i_req.fetch && i_req.pg_xd && i_mods.exec_disable_enable) begin
            deny = 1'b1;
        end
    end

    // registered answer one cycle after the request
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_rsp <= '0;
        end else begin
            o_rsp.valid <= i_req.valid;
            o_rsp.gp    <= 1'b0;
            o_rsp.deny  <= 1'b0;
            o_rsp.lin   <= '0;
            o_rsp.phys  <= '0;
            if (i_mode == PMC_MODE_OFF) begin
                o_rsp.phys <= 52'(i_req.lin[PMC_LEG_W-1:0]);
            end else if (i_mode == PMC_MODE_FOUR && i_req.sub64) begin
                o_rsp.gp <= i_req.valid & ~canon_ok;
                if (canon_ok) begin
                    o_rsp.lin  <= i_req.lin[PMC_LIN_W-1:0];
                    o_rsp.phys <= i_req.walk_phys & phys_mask;
                    o_rsp.deny <= deny;
                end
            end else begin
                o_rsp.lin  <= 48'(i_req.lin[PMC_LEG_W-1:0]);
                o_rsp.phys <= i_req.walk_phys & phys_mask;
                o_rsp.deny <= deny;
            end
        end
    end

    property p_noncanon_gp;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_req.valid && i_mode == PMC_MODE_FOUR && i_req.sub64 && !canon_ok)
            |=> (o_rsp.gp && o_rsp.phys == '0);
    endproperty
    a_noncanon_gp: assert property (p_noncanon_gp) else $error("no fault on bad address");

    property p_ro_write;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_mode == PMC_MODE_TWO && i_req.write && i_req.pg_ro && i_req.current_privilege == PMC_CPL_USER)
            |=> o_rsp.deny;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("user write to read-only passed");
endmodule : pmc_xlate_chk
`default_nettype wire

/* core/pmc_paging_ctrl.sv */
// paging mode control: control words, mode selection, fault checks
`timescale 1ns/100ps
`default_nettype none
module pmc_paging_ctrl import pmc_pkg::*; (
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    // axi4-lite slave
    input  wire logic [3:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output var  logic        o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output var  logic        o_wready,
    output var  logic [1:0]  o_bresp,
    output var  logic        o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [3:0]  i_araddr,
    input  wire logic        i_arvalid,
    output var  logic        o_arready,
    output var  logic [31:0] o_rdata,
    output var  logic [1:0]  o_rresp,
    output var  logic        o_rvalid,
    input  wire logic        i_rready,
    // translation path
    input  wire pmc_xl_req_t i_xl_req,
    output var  pmc_xl_rsp_t o_xl_rsp,
    output var  pmc_mode_t   o_mode,
    output var  pmc_mods_t   o_mods,
    output var  logic        o_gp_fault,
    output var  logic [15:0] o_gp_code
);
    logic [31:0] cw0_ff;
    logic [31:0] cw4_ff;
    logic [31:0] efr_ff;
    pmc_mode_t   mode_ff;
    logic [7:0]  fault_cnt_ff;
    logic        aw_ok_ff;
    logic        w_ok_ff;
    logic [3:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        gp_ff;
    logic        commit;
    logic        fault;
    logic        mapped;
    logic [31:0] merged;
    logic [31:0] nxt_cw0;
    logic [31:0] nxt_cw4;
    logic [31:0] nxt_efr;
    logic        pg;
    logic        phys_extension_bit;
    logic        long_enable;

    // merge write data into a register by byte strobes
    function automatic logic [31:0] pmc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // mode from paging, extension and long-enable bits
    function automatic pmc_mode_t pmc_sel_mode(input logic pg_v,
                                               input logic pae_v,
                                               input logic lme_v);
        pmc_mode_t m;
        m = PMC_MODE_OFF;
        if (pg_v && !pae_v) begin
            m = PMC_MODE_TWO;
        end else if (pg_v && !lme_v) begin
            m = PMC_MODE_EXT;
        end else if (pg_v) begin
            m = PMC_MODE_FOUR;
        end
        return m;
    endfunction

    assign pg  = cw0_ff[PMC_B_PG];
    assign phys_extension_bit = cw4_ff[PMC_B_PAE];
    assign long_enable = efr_ff[PMC_B_LME];

    // write channel handshakes: one write in flight, either order
    assign o_awready = ~aw_ok_ff & ~bvalid_ff;
    assign o_wready  = ~w_ok_ff & ~bvalid_ff;
    assign o_bvalid  = bvalid_ff;
    assign o_bresp   = bresp_ff;
    assign o_arready = ~rvalid_ff;
    assign o_rvalid  = rvalid_ff;
    assign o_rdata   = rdata_ff;
    assign o_rresp   = rresp_ff;
    assign commit    = aw_ok_ff & w_ok_ff & ~bvalid_ff;
    assign mapped    = (awaddr_ff == PMC_OFF_CW0) || (awaddr_ff == PMC_OFF_CW4)
                    || (awaddr_ff == PMC_OFF_EFR);

    // candidate values and legality of the pending write
    always_comb begin
        nxt_cw0 = cw0_ff;
        nxt_cw4 = cw4_ff;
        nxt_efr = efr_ff;
        fault   = 1'b0;
        merged  = '0;
        case (awaddr_ff)
            PMC_OFF_CW0: begin
                merged  = pmc_merge(cw0_ff, wdata_ff, wstrb_ff);
                nxt_cw0 = merged & PMC_MASK_CW0;
                if (nxt_cw0[PMC_B_PG] && !nxt_cw0[PMC_B_PE]) begin
                    fault = 1'b1;
                end
                if (nxt_cw0[PMC_B_PG] && !pg && !phys_extension_bit && long_enable) begin
                    fault = 1'b1;
                end
                if (!nxt_cw0[PMC_B_PG] && pg && cw4_ff[PMC_B_CID]) begin
                    fault = 1'b1;
                end
            end
            PMC_OFF_CW4: begin
                merged  = pmc_merge(cw4_ff, wdata_ff, wstrb_ff);
                nxt_cw4 = merged & PMC_MASK_CW4;
                if (pg && long_enable && !nxt_cw4[PMC_B_PAE]) begin
                    fault = 1'b1;
                end
                if (nxt_cw4[PMC_B_CID] && !cw4_ff[PMC_B_CID] && mode_ff != PMC_MODE_FOUR) begin
                    fault = 1'b1;
                end
            end
            PMC_OFF_EFR: begin
                merged  = pmc_merge(efr_ff, wdata_ff, wstrb_ff);
                nxt_efr = merged & PMC_MASK_EFR;
                if (pg && (nxt_efr[PMC_B_LME] != long_enable)) begin
                    fault = 1'b1;
                end
            end
            default: begin
                fault = 1'b0;
            end
        endcase
    end

    // control registers: rejected writes change nothing
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cw0_ff <= PMC_RST_REG;
            cw4_ff <= PMC_RST_REG;
            efr_ff <= PMC_RST_REG;
        end else if (commit && mapped && !fault) begin
            cw0_ff <= nxt_cw0;
            cw4_ff <= nxt_cw4;
            efr_ff <= nxt_efr;
        end
    end

    // mode register recomputed with the accepted write
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            mode_ff <= PMC_MODE_OFF;
        end else if (commit && mapped && !fault) begin
            mode_ff <= pmc_sel_mode(nxt_cw0[PMC_B_PG], nxt_cw4[PMC_B_PAE],
                                    nxt_efr[PMC_B_LME]);
        end
    end

    // fault pulse and saturating count of rejected writes
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            gp_ff        <= 1'b0;
            fault_cnt_ff <= '0;
        end else begin
            gp_ff <= commit & mapped & fault;
            if (commit && mapped && fault && fault_cnt_ff != '1) begin
                fault_cnt_ff <= fault_cnt_ff + 8'h01;
            end
        end
    end

    // write address and data holding, then response
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            aw_ok_ff  <= 1'b0;
            w_ok_ff   <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= '0;
            wstrb_ff  <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= PMC_RESP_OK;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_ok_ff  <= 1'b1;
                awaddr_ff <= {i_awaddr[3:2], 2'h0};
            end
            if (i_wvalid && o_wready) begin
                w_ok_ff  <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (commit) begin
                aw_ok_ff  <= 1'b0;
                w_ok_ff   <= 1'b0;
                bvalid_ff <= 1'b1;
                // a rejected write answers slverr so the pipeline sees it
                bresp_ff  <= !mapped ? PMC_RESP_DEC : (fault ? PMC_RESP_SLV : PMC_RESP_OK);
            end else if (bvalid_ff && i_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read channel: status word is live, long-active derived not stored
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= PMC_RESP_OK;
        end else if (i_arvalid && o_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= PMC_RESP_OK;
            rdata_ff  <= '0;
            case ({i_araddr[3:2], 2'h0})
                PMC_OFF_CW0: rdata_ff <= cw0_ff;
                PMC_OFF_CW4: rdata_ff <= cw4_ff;
                PMC_OFF_EFR: begin
                    rdata_ff             <= efr_ff;
                    rdata_ff[PMC_B_LMA]  <= pg & long_enable;
                end
                PMC_OFF_STAT: rdata_ff <= {16'h0000, fault_cnt_ff, 6'h00, mode_ff};
                default: begin
                    rresp_ff <= PMC_RESP_DEC;
                end
            endcase
        end else if (rvalid_ff && i_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // effective modifiers, each only in the modes that honour it
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_mods <= '0;
        end else begin
            o_mods.wp   <= (mode_ff != PMC_MODE_OFF) & cw0_ff[PMC_B_WP];
            o_mods.large_page_enable  <= (mode_ff == PMC_MODE_TWO) & cw4_ff[PMC_B_PSE];
            o_mods.global_page_enable  <= (mode_ff != PMC_MODE_OFF) & cw4_ff[PMC_B_PGE];
            o_mods.cid  <= (mode_ff == PMC_MODE_FOUR) & cw4_ff[PMC_B_CID];
            o_mods.sup_exec_prevent <= (mode_ff != PMC_MODE_OFF) & cw4_ff[PMC_B_SMP];
            o_mods.exec_disable_enable  <= (mode_ff == PMC_MODE_EXT || mode_ff == PMC_MODE_FOUR)
                           & efr_ff[PMC_B_NXE];
        end
    end

    assign o_mode     = mode_ff;
    assign o_gp_fault = gp_ff;
    assign o_gp_code  = PMC_GP_CODE;

    // address width, canonical and permission checking
    pmc_xlate_chk u_chk (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_mode    (mode_ff),
        .i_mods    (o_mods),
        .i_req     (i_xl_req),
        .o_rsp     (o_xl_rsp)
    );

    property p_mode_off;
        @(posedge i_ref_clk) disable iff (i_srst)
        (mode_ff == PMC_MODE_OFF) [*2] |-> (o_mods == '0);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("modifier active with paging off");

    property p_pg_pe;
        @(posedge i_ref_clk) disable iff (i_srst)
        cw0_ff[PMC_B_PG] |-> cw0_ff[PMC_B_PE];
    endproperty
    a_pg_pe: assert property (p_pg_pe) else $error("paging on without protection");

    property p_mode_sel;
        @(posedge i_ref_clk) disable iff (i_srst)
        (commit && mapped && !fault) |=>
            (mode_ff == pmc_sel_mode(pg, phys_extension_bit, long_enable) && !gp_ff);
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("mode does not follow bits");

    property p_two_lme;
        @(posedge i_ref_clk) disable iff (i_srst)
        (pg && !phys_extension_bit) |-> !long_enable;
    endproperty
    a_two_lme: assert property (p_two_lme) else $error("long enable set in two-level");

    property p_lme_locked;
        @(posedge i_ref_clk) disable iff (i_srst)
        (pg && $past(pg)) |-> $stable(long_enable);
    endproperty
    a_lme_locked: assert property (p_lme_locked) else $error("long enable moved while paging");

    property p_reject;
        @(posedge i_ref_clk) disable iff (i_srst)
        (commit && mapped && fault) |=>
            (gp_ff && $stable(cw0_ff) && $stable(cw4_ff) && $stable(efr_ff))
            ##1 (bresp_ff == PMC_RESP_SLV);
    endproperty
    a_reject: assert property (p_reject) else $error("rejected write altered state");

    property p_cid_pg;
        @(posedge i_ref_clk) disable iff (i_srst)
        (pg && cw4_ff[PMC_B_CID]) |=> pg;
    endproperty
    a_cid_pg: assert property (p_cid_pg) else $error("paging cleared with context ids");

    property p_four_pae;
        @(posedge i_ref_clk) disable iff (i_srst)
        (pg && long_enable) |=> phys_extension_bit;
    endproperty
    a_four_pae: assert property (p_four_pae) else $error("extension cleared in four-level");
endmodule : pmc_paging_ctrl
`default_nettype wire

/* verification/pmc_walk_model.sv */
// walker and pipeline model feeding translation requests to the control block
`timescale 1ns/100ps
`default_nettype none
module pmc_walk_model import pmc_pkg::*; (
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    input  wire logic        i_go,
    input  wire logic [63:0] i_lin,
    input  wire logic        i_sub64,
    input  wire logic [1:0]  i_cpl,
    input  wire logic [5:0]  i_flags,
    output var  pmc_xl_req_t o_req
);
    // one request per go cycle; idle cycles flip every field but valid, which clears, so stale data never looks fresh
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_req <= '0;
        end else if (i_go) begin
            o_req <= '{valid: 1'b1, lin: i_lin, sub64: i_sub64, current_privilege: i_cpl,
                       write: i_flags[4], fetch: i_flags[3], pg_ro: i_flags[2],
                       pg_user: i_flags[1], pg_xd: i_flags[0], pg_large: i_flags[5],
                       walk_phys: '1}; // all ones so every width mask shows
        end else begin
            o_req       <= ~o_req;
            o_req.valid <= 1'b0;
        end
    end
endmodule // pmc_walk_model
`default_nettype wire

/* verification/pmc_paging_ctrl_tb_top.sv */
// bench for paging mode control: bus tasks and mode sequence tests
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module pmc_paging_ctrl_tb_top import pmc_pkg::*;;
    logic        clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, go = 1'b0, sub = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, gpf;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp, current_privilege = 2'h0;
    logic [5:0]  fl = 6'h0;
    logic [63:0] lin = 64'h0;
    logic [15:0] gpc;
    pmc_xl_req_t req;
    pmc_xl_rsp_t rsp;
    pmc_mode_t   mode;
    pmc_mods_t   mods;
    int          err_count = 0, n_checks = 0, cyc = 0;

    always #4 clk = ~clk;

    pmc_walk_model pmc_walk_model_inst (.i_ref_clk(clk), .i_srst(srst), .i_go(go),
        .i_lin(lin), .i_sub64(sub), .i_cpl(current_privilege), .i_flags(fl), .o_req(req));

    pmc_paging_ctrl pmc_paging_ctrl_inst (.i_ref_clk(clk), .i_srst(srst),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_xl_req(req), .o_xl_rsp(rsp), .o_mode(mode), .o_mods(mods),
        .o_gp_fault(gpf), .o_gp_code(gpc));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // a hung handshake would stall forever, so a cycle ceiling ends the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er,
                      input logic eg);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        `CHK("bresp", er, bresp)
        `CHK("gp_fault", eg, gpf)
        `CHK("gp_code", PMC_GP_CODE, gpc)
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] ed);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        `CHK("rdata", ed, rdata)
        `CHK("rresp", PMC_RESP_OK, rresp)
        rready <= 1'b0;
    endtask

    // flags: large, write, fetch, read-only, user, exec-disable
    task automatic xl(input logic [63:0] l, input logic s, input logic [1:0] c,
                      input logic [5:0] f, input logic eg, input logic ed,
                      input logic [47:0] el, input logic [51:0] ep);
        @(posedge clk);
        go  <= 1'b1;
        lin <= l;
        sub <= s;
        current_privilege <= c;
        fl  <= f;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("xl_valid", 1'b1, rsp.valid)
        `CHK("xl_gp", eg, rsp.gp)
        `CHK("xl_deny", ed, rsp.deny)
        `CHK("xl_lin", el, rsp.lin)
        `CHK("xl_phys", ep, rsp.phys)
    endtask

    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 4; i++) rd(4'(i * 4), 32'h0);
        // status is read-only: the write is refused as unmapped, no fault counted
        wr(PMC_OFF_STAT, 32'h0000_00ff, PMC_RESP_DEC, 1'b0);
        // no walk with paging off, so the linear field stays zero and physical is the low 32 bits
        xl(64'h1234_5678_9abc_def0, 1'b0, 2'h3, 6'h3f, 1'b0, 1'b0, 48'h0,
           52'h9abc_def0);
        $display("reset and paging off test done");
        wr(PMC_OFF_CW0, 32'h8000_0000, PMC_RESP_SLV, 1'b1);
        `CHK("mode", PMC_MODE_OFF, mode)
        wr(PMC_OFF_CW0, 32'h8000_0001, PMC_RESP_OK, 1'b0);
        `CHK("mode", PMC_MODE_TWO, mode)
        rd(PMC_OFF_STAT, 32'h0000_0101);
        wr(PMC_OFF_CW4, 32'h0000_0010, PMC_RESP_OK, 1'b0);
        wr(PMC_OFF_EFR, 32'h0000_0800, PMC_RESP_OK, 1'b0);
        xl(64'h0040_0000, 1'b0, 2'h0, 6'h20, 1'b0, 1'b0, 48'h40_0000,
           52'hff_ffff_ffff);
        xl(64'h0040_0000, 1'b0, 2'h0, 6'h09, 1'b0, 1'b0, 48'h40_0000,
           52'hffff_ffff);
        $display("two-level test done");
        wr(PMC_OFF_CW4, 32'h0000_0030, PMC_RESP_OK, 1'b0);
        `CHK("mode", PMC_MODE_EXT, mode)
        xl(64'h0040_0000, 1'b0, 2'h0, 6'h29, 1'b0, 1'b1, 48'h40_0000,
           52'hf_ffff_ffff_ffff);
        // large pages dropped outside two-level, execute disable now honoured
        `CHK("mods", 6'h01, mods)
        wr(PMC_OFF_CW4, 32'h0002_0030, PMC_RESP_SLV, 1'b1);
        wr(PMC_OFF_EFR, 32'h0000_0900, PMC_RESP_SLV, 1'b1);
        wr(PMC_OFF_CW4, 32'h0000_0010, PMC_RESP_OK, 1'b0);
        `CHK("mode", PMC_MODE_TWO, mode)
        $display("extended test done");
        wr(PMC_OFF_CW0, 32'h0000_0001, PMC_RESP_OK, 1'b0);
        wr(PMC_OFF_EFR, 32'h0000_0d00, PMC_RESP_OK, 1'b0);
        rd(PMC_OFF_EFR, 32'h0000_0900);
        wr(PMC_OFF_CW0, 32'h8000_0001, PMC_RESP_SLV, 1'b1);
        wr(PMC_OFF_CW4, 32'h0000_0020, PMC_RESP_OK, 1'b0);
        wr(PMC_OFF_CW0, 32'h8000_0001, PMC_RESP_OK, 1'b0);
        `CHK("mode", PMC_MODE_FOUR, mode)
        rd(PMC_OFF_EFR, 32'h0000_0d00);
        rd(PMC_OFF_STAT, 32'h0000_0403);
        $display("four-level entry test done");
        wr(PMC_OFF_CW4, 32'h0000_0000, PMC_RESP_SLV, 1'b1);
        wr(PMC_OFF_CW4, 32'h0012_00a0, PMC_RESP_OK, 1'b0);
        wr(PMC_OFF_CW0, 32'h0000_0001, PMC_RESP_SLV, 1'b1);
        `CHK("mode", PMC_MODE_FOUR, mode)
        xl(64'h0000_8000_0000_0000, 1'b1, 2'h0, 6'h00, 1'b1, 1'b0, 48'h0, 52'h0);
        xl(64'hffff_8000_0000_1000, 1'b1, 2'h0, 6'h00, 1'b0, 1'b0, 48'h8000_0000_1000,
           52'hf_ffff_ffff_ffff);
        xl(64'h1234_5678_9abc_def0, 1'b0, 2'h0, 6'h00, 1'b0, 1'b0, 48'h9abc_def0,
           52'hf_ffff_ffff_ffff);
        xl(64'h1000, 1'b0, 2'h0, 6'h14, 1'b0, 1'b0, 48'h1000, 52'hf_ffff_ffff_ffff);
        xl(64'h1000, 1'b0, 2'h3, 6'h14, 1'b0, 1'b1, 48'h1000, 52'hf_ffff_ffff_ffff);
        xl(64'h1000, 1'b0, 2'h0, 6'h0a, 1'b0, 1'b1, 48'h1000, 52'hf_ffff_ffff_ffff);
        // four-level: global, context ids, fetch guard and execute disable all live
        `CHK("mods", 6'h0f, mods)
        wr(PMC_OFF_CW0, 32'h8001_0001, PMC_RESP_OK, 1'b0);
        xl(64'h1000, 1'b0, 2'h0, 6'h14, 1'b0, 1'b1, 48'h1000, 52'hf_ffff_ffff_ffff);
        $display("four-level test done");
        wr(PMC_OFF_CW4, 32'h0000_0020, PMC_RESP_OK, 1'b0);
        wr(PMC_OFF_CW0, 32'h0000_0001, PMC_RESP_OK, 1'b0);
        `CHK("mode", PMC_MODE_OFF, mode)
        rd(PMC_OFF_STAT, 32'h0000_0600);
        // execute disable is still set in the feature register but must be masked
        `CHK("mods", 6'h00, mods)
        $display("exit test done");
        complete_run();
    end
endmodule // pmc_paging_ctrl_tb_top
`default_nettype wire
